// ==== verilog/dcp_regs.vh ====
// Overview of operation
// - source position register reads a 16-bit byte offset, zero is first byte
// - in pattern mode a detected pattern clears the source position
// - destination position register reads a 16-bit byte offset into target
// - writable 16-bit cell size sets bytes moved for each trigger event
// - cell position counts bytes in cell, cleared at reset, on start, at cell end and on pattern
// - pointer and cell size registers keep bits 15:0, bits 31:16 read zero
// - 8-bit read/write match byte in bits 7:0, resets to zero
// - pattern mode compares moved bytes with match byte, ends on a match
// - writable 16-bit source length limits how far the source advances
`ifndef DCP_REGS_VH
`define DCP_REGS_VH

`define DCP_ADDR_CTRL     6'h00
`define DCP_ADDR_STATUS   6'h04
`define DCP_ADDR_SRC_LEN  6'h08
`define DCP_ADDR_SRC_POS  6'h10
`define DCP_ADDR_DST_POS  6'h14
`define DCP_ADDR_CELL_SZ  6'h18
`define DCP_ADDR_CELL_POS 6'h1c
`define DCP_ADDR_MATCH    6'h20

`define DCP_CTRL_START    0
`define DCP_CTRL_PATTERN  1
`define DCP_STAT_BUSY     0
`define DCP_STAT_DONE     1
`define DCP_STAT_MATCH    2

`define DCP_RST_POS       16'h0000
`define DCP_RST_SIZE      16'h0000
`define DCP_RST_MATCH     8'h00

`define DCP_WAIT_STATES   1

`endif

// ==== verilog/dcp_pos_cnt.v ====
`timescale 1ns/1ns
module dcp_pos_cnt
#(
	parameter WIDTH = 16
)
(
	ref_clk,
	nrst,
	clr,
	inc,
	cnt_q
);
	input  wire             ref_clk;
	input  wire             nrst;
	input  wire             clr;
	input  wire             inc;
	output reg  [WIDTH-1:0] cnt_q;

	reg [WIDTH-1:0] cnt_d;

	// clear beats increment
	always @*
	begin
		cnt_d = cnt_q;
		if (clr)
			cnt_d = {WIDTH{1'b0}};
		else if (inc)
			cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= {WIDTH{1'b0}};
		else
			cnt_q <= cnt_d;
	end
endmodule

// ==== verilog/dcp_buf2.v ====
`timescale 1ns/1ns
module dcp_buf2
#(
	parameter WIDTH = 8,
	parameter DEPTH = 2
)
(
	ref_clk,
	nrst,
	in_valid,
	in_data,
	in_ready,
	out_valid,
	out_data,
	out_ready
);
	input  wire             ref_clk;
	input  wire             nrst;
	input  wire             in_valid;
	input  wire [WIDTH-1:0] in_data;
	output wire             in_ready;
	output wire             out_valid;
	output wire [WIDTH-1:0] out_data;
	input  wire             out_ready;

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg             wp_q;
	reg             rp_q;
	reg [1:0]       cnt_q;
	wire            push;
	wire            pop;
	integer         i;

	assign in_ready  = (cnt_q != DEPTH[1:0]);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_q[wp_q] <= in_data;
				wp_q        <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			if (push & ~pop)
				cnt_q <= cnt_q + 2'h1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 2'h1;
		end
	end
endmodule

// ==== verilog/dcp_channel.v ====
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "dcp_regs.vh"
module dcp_channel
#(
	parameter PW = 16
)
(
	ref_clk,
	nrst,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	trig_event,
	src_valid,
	src_data,
	src_ready,
	dst_valid,
	dst_data,
	dst_ready,
	xfer_busy
);
	input  wire        ref_clk;
	input  wire        nrst;
	input  wire [5:0]  avs_address;
	input  wire        avs_read;
	input  wire        avs_write;
	input  wire [31:0] avs_writedata;
	input  wire [3:0]  avs_byteenable;
	output reg  [31:0] avs_readdata;
	output wire        avs_waitrequest;
	input  wire        trig_event;
	input  wire        src_valid;
	input  wire [7:0]  src_data;
	output wire        src_ready;
	output wire        dst_valid;
	output wire [7:0]  dst_data;
	input  wire        dst_ready;
	output wire        xfer_busy;

	reg           ack_q;
	reg           pat_mode_q;
	reg           busy_q;
	reg           cell_act_q;
	reg           done_q;
	reg           hit_q;
	reg  [PW-1:0] cell_size_q;
	reg  [PW-1:0] src_len_q;
	reg  [7:0]    match_q;
	reg           busy_d;
	reg           cell_act_d;
	reg  [31:0]   rdata_d;

	wire [PW-1:0] src_pos;
	wire [PW-1:0] dst_pos;
	wire [PW-1:0] cell_pos;
	wire          req;
	wire          wr_ack;
	wire          buf_in_ready;
	wire          src_take;
	wire          dst_take;
	wire          hit;
	wire          src_last;
	wire          cell_last;
	wire          src_end;
	wire          cell_end;
	wire          start;
	wire          ctrl_wr;
	wire          stat_wr;
	wire          cell_sz_wr;
	wire          src_len_wr;
	wire          match_wr;

	// true when the word address matches a register offset
	function sel;
		input [5:0] addr;
		input [5:0] off;
		begin
			sel = (addr[5:2] == off[5:2]);
		end
	endfunction

	// merge byte lanes of a write into a 16-bit field
	function [15:0] lane16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  be;
		begin
			lane16[7:0]  = be[0] ? wd[7:0] : old[7:0];
			lane16[15:8] = be[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	// one wait state, then the answer
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_ack          = avs_write & ack_q;

	assign ctrl_wr = wr_ack & sel(avs_address, `DCP_ADDR_CTRL) &
		avs_byteenable[0];
	assign stat_wr = wr_ack & sel(avs_address, `DCP_ADDR_STATUS) &
		avs_byteenable[0];
	assign start   = ctrl_wr & avs_writedata[`DCP_CTRL_START] & ~busy_q &
		(src_len_q != `DCP_RST_SIZE);

	// register write strobes, only on the acknowledged cycle
	assign cell_sz_wr = wr_ack & sel(avs_address, `DCP_ADDR_CELL_SZ);
	assign src_len_wr = wr_ack & sel(avs_address, `DCP_ADDR_SRC_LEN);
	assign match_wr   = wr_ack & sel(avs_address, `DCP_ADDR_MATCH) &
		avs_byteenable[0];

	assign src_ready = buf_in_ready & busy_q & cell_act_q;
	assign src_take  = src_valid & src_ready;
	assign dst_take  = dst_valid & dst_ready;
	assign xfer_busy = busy_q;

	assign hit       = src_take & pat_mode_q & (src_data == match_q);
	assign src_last  = (src_pos + 16'h0001) == src_len_q;
	assign cell_last = (cell_pos + 16'h0001) == cell_size_q;
	assign src_end   = src_take & src_last;
	assign cell_end  = src_take & cell_last;

	// byte positions, a clear beats a byte in the same cycle
	dcp_pos_cnt
	#(
		.WIDTH (PW)
	)
	u_src_cnt
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clr     (start | hit),
		.inc     (src_take),
		.cnt_q   (src_pos)
	);

	dcp_pos_cnt
	#(
		.WIDTH (PW)
	)
	u_dst_cnt
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clr     (start),
		.inc     (dst_take),
		.cnt_q   (dst_pos)
	);

	dcp_pos_cnt
	#(
		.WIDTH (PW)
	)
	u_cell_cnt
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clr     (start | hit | cell_end),
		.inc     (src_take),
		.cnt_q   (cell_pos)
	);

	dcp_buf2
	#(
		.WIDTH (8),
		.DEPTH (2)
	)
	u_buf
	(
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (src_valid & busy_q & cell_act_q),
		.in_data   (src_data),
		.in_ready  (buf_in_ready),
		.out_valid (dst_valid),
		.out_data  (dst_data),
		.out_ready (dst_ready)
	);

	// channel and cell sequencing
	always @*
	begin
		busy_d     = busy_q;
		cell_act_d = cell_act_q;
		if (start)
		begin
			busy_d     = 1'b1;
			cell_act_d = 1'b0;
		end
		else if (hit | src_end)
		begin
			busy_d     = 1'b0;
			cell_act_d = 1'b0;
		end
		else if (cell_end)
			cell_act_d = 1'b0;
		else if (trig_event & busy_q & ~cell_act_q &
			(cell_size_q != `DCP_RST_SIZE))
			cell_act_d = 1'b1;
	end

	// read mux, unmapped words and unused bits read zero
	always @*
	begin
		rdata_d = 32'h00000000;
		case ({avs_address[5:2], 2'b00})
			`DCP_ADDR_CTRL:
				rdata_d[`DCP_CTRL_PATTERN] = pat_mode_q;
			`DCP_ADDR_STATUS:
			begin
				rdata_d[`DCP_STAT_BUSY]  = busy_q;
				rdata_d[`DCP_STAT_DONE]  = done_q;
				rdata_d[`DCP_STAT_MATCH] = hit_q;
			end
			`DCP_ADDR_SRC_LEN:
				rdata_d[15:0] = src_len_q;
			`DCP_ADDR_SRC_POS:
				rdata_d[15:0] = src_pos;
			`DCP_ADDR_DST_POS:
				rdata_d[15:0] = dst_pos;
			`DCP_ADDR_CELL_SZ:
				rdata_d[15:0] = cell_size_q;
			`DCP_ADDR_CELL_POS:
				rdata_d[15:0] = cell_pos;
			`DCP_ADDR_MATCH:
				rdata_d[7:0] = match_q;
			default:
				rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q)
				avs_readdata <= rdata_d;
		end
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pat_mode_q  <= 1'b0;
			busy_q      <= 1'b0;
			cell_act_q  <= 1'b0;
			cell_size_q <= `DCP_RST_SIZE;
			src_len_q   <= `DCP_RST_SIZE;
			match_q     <= `DCP_RST_MATCH;
		end
		else
		begin
			busy_q     <= busy_d;
			cell_act_q <= cell_act_d;
			if (ctrl_wr)
				pat_mode_q <= avs_writedata[`DCP_CTRL_PATTERN];
			if (cell_sz_wr)
				cell_size_q <= lane16(cell_size_q, avs_writedata,
					avs_byteenable);
			if (src_len_wr)
				src_len_q <= lane16(src_len_q, avs_writedata,
					avs_byteenable);
			if (match_wr)
				match_q <= avs_writedata[7:0];
		end
	end

	// sticky flags, a new event wins over the clear
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			done_q <= 1'b0;
			hit_q  <= 1'b0;
		end
		else
		begin
			if (src_end & ~hit)
				done_q <= 1'b1;
			else if (start)
				done_q <= 1'b0;
			else if (stat_wr & avs_writedata[`DCP_STAT_DONE])
				done_q <= 1'b0;
			if (hit)
				hit_q <= 1'b1;
			else if (start)
				hit_q <= 1'b0;
			else if (stat_wr & avs_writedata[`DCP_STAT_MATCH])
				hit_q <= 1'b0;
		end
	end
endmodule

// ==== tb/dcp_channel_sva.sv ====
`timescale 1ns/1ns
`include "dcp_regs.vh"
module dcp_channel_sva (
	input wire        ref_clk,
	input wire        nrst,
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        src_valid,
	input wire [7:0]  src_data,
	input wire        src_ready,
	input wire        dst_valid,
	input wire [7:0]  dst_data,
	input wire        dst_ready,
	input wire        xfer_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire       wr = avs_write && !avs_waitrequest;
	wire       acc = src_valid && src_ready;
	logic      mode_q;
	logic [7:0]  mval_q;
	logic [15:0] len_q;
	logic [15:0] cnt_q;
	always @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			mode_q <= 1'b0;
			mval_q <= 8'h00;
			len_q <= 16'h0000;
			cnt_q <= 16'h0000;
		end
		else
		begin
			if (wr && avs_address == `DCP_ADDR_MATCH)
				mval_q <= avs_writedata[7:0];
			if (wr && avs_address == `DCP_ADDR_SRC_LEN)
				len_q <= avs_writedata[15:0];
			if (wr && avs_address == `DCP_ADDR_CTRL)
				mode_q <= avs_writedata[`DCP_CTRL_PATTERN];
			if (wr && avs_address == `DCP_ADDR_CTRL)
				cnt_q <= 16'h0000;
			else if (acc)
				cnt_q <= cnt_q + 16'h0001;
		end
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest;
	endsequence
	AST_ONE_WAIT:
		assert property (s_req |=> s_ack) else $error("no ack");
	AST_IDLE_NOWAIT:
		assert property (!(avs_read || avs_write) |-> s_ack) else $error("idle");
	AST_UPPER_ZERO:
		assert property (avs_read && !avs_waitrequest
			&& avs_address[5:2] > 4'h1
			|-> avs_readdata[31:16] == 16'h0000) else $error("upper");
	AST_MATCH_READ:
		assert property (avs_read && !avs_waitrequest
			&& avs_address == `DCP_ADDR_MATCH
			|-> avs_readdata == {24'h0, mval_q}) else $error("match rd");
	AST_NO_SRC_IDLE:
		assert property (!xfer_busy |-> !src_ready) else $error("src idle");
	AST_DST_HOLD:
		assert property (dst_valid && !dst_ready
			|=> dst_valid && $stable(dst_data)) else $error("dst hold");
	AST_PAT_END:
		assert property (acc && mode_q && src_data == mval_q
			|-> ##[1:2] !xfer_busy) else $error("pattern");
	AST_LEN_END:
		assert property ($fell(xfer_busy) && !mode_q |-> cnt_q == len_q)
			else $error("length");
	AST_START:
		assert property (wr && avs_address == `DCP_ADDR_CTRL
			&& avs_writedata[0] && !xfer_busy && len_q != 16'h0000
			|-> ##[1:2] xfer_busy) else $error("start");
endmodule
bind dcp_channel dcp_channel_sva i_dcp_channel_sva (.ref_clk(ref_clk),
	.nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
	.dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
	.xfer_busy(xfer_busy));

// ==== tb/dcp_mem_model.sv ====
`timescale 1ns/1ns
module dcp_mem_model (
	input wire       ref_clk,
	input wire       nrst,
	input wire       go,
	input wire       slow,
	input wire [7:0] base,
	output reg       src_valid,
	output reg [7:0] src_data,
	input wire       src_ready,
	output reg       dst_ready
);
	reg [7:0] n_q;
	reg       tog_q;
	// slow mode offers and takes a byte only every other cycle
	wire      fire = go && (!slow || tog_q);
	always @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			src_valid <= 1'b0;
			src_data <= 8'h00;
			dst_ready <= 1'b0;
			n_q <= 8'h00;
			tog_q <= 1'b0;
		end
		else
		begin
			tog_q <= !tog_q;
			dst_ready <= !slow || !tog_q;
			if (!go)
			begin
				src_valid <= 1'b0;
				src_data <= ~src_data;
				n_q <= 8'h00;
			end
			else if (!src_valid || src_ready)
			begin
				src_valid <= fire;
				n_q <= n_q + {7'h00, fire};
				src_data <= fire ? base + n_q : ~src_data;
			end
		end
endmodule

// ==== tb/dcp_channel_tb.sv ====
`timescale 1ns/1ns
`include "dcp_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module dcp_channel_tb;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic        trig_event = 1'b0;
	logic        go = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] ev;
	logic [7:0]  base = 8'h00;
	logic [7:0]  rs = 8'h16;
	logic [7:0]  eb;
	wire  [31:0] avs_readdata;
	wire  [7:0]  src_data, dst_data;
	wire         avs_waitrequest, src_valid, src_ready;
	wire         dst_valid, dst_ready, xfer_busy;
	int          n_mismatch = 0, tests_run = 0, cyc = 0, n_acc = 0, i;
	logic [31:0] rq[$];
	logic [7:0]  dq[$];
	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end
	dcp_channel i_dcp_channel (.ref_clk(ref_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trig_event(trig_event),
		.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
		.dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
		.xfer_busy(xfer_busy));
	dcp_mem_model i_dcp_mem_model (.ref_clk(ref_clk), .nrst(nrst), .go(go),
		.slow(1'b1), .base(base), .src_valid(src_valid),
		.src_data(src_data), .src_ready(src_ready), .dst_ready(dst_ready));
	function automatic [7:0] lfsr(input [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge ref_clk);
		while (avs_waitrequest)
			@(posedge ref_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task rdx(input logic [5:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task pulse;
		@(posedge ref_clk);
		trig_event <= 1'b1;
		@(posedge ref_clk);
		trig_event <= 1'b0;
	endtask
	task settle(input int n);
		while (n_acc < n || dq.size() != 0)
			@(posedge ref_clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// pre-edge values, as the design samples them
	always @(posedge ref_clk)
	begin
		if (avs_read && !avs_waitrequest)
		begin
			ev = rq.pop_front();
			`CHK("readdata", ev, avs_readdata)
		end
		if (src_valid && src_ready)
		begin
			dq.push_back(src_data);
			n_acc++;
		end
		if (dst_valid && dst_ready)
		begin
			eb = dq.pop_front();
			`CHK("dst_data", eb, dst_data)
		end
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		for (i = 0; i < 9; i++)
			rdx(6'(i * 4), 32'h0);
		for (i = 2; i < 9; i++)
			bus(1'b1, 6'(i * 4), 32'hffffffff);
		rdx(`DCP_ADDR_SRC_LEN, 32'h0000ffff);
		rdx(6'h0c, 32'h0);
		rdx(`DCP_ADDR_SRC_POS, 32'h0);
		rdx(`DCP_ADDR_DST_POS, 32'h0);
		rdx(`DCP_ADDR_CELL_SZ, 32'h0000ffff);
		rdx(`DCP_ADDR_CELL_POS, 32'h0);
		rdx(`DCP_ADDR_MATCH, 32'h000000ff);
		$display("test registers done");
		base <= rs;
		rs <= lfsr(rs);
		go <= 1'b1;
		bus(1'b1, `DCP_ADDR_SRC_LEN, 32'h6);
		bus(1'b1, `DCP_ADDR_CELL_SZ, 32'h4);
		bus(1'b1, `DCP_ADDR_CTRL, 32'h1);
		pulse();
		settle(4);
		rdx(`DCP_ADDR_SRC_POS, 32'h4);
		rdx(`DCP_ADDR_CELL_POS, 32'h0);
		rdx(`DCP_ADDR_DST_POS, 32'h4);
		pulse();
		settle(6);
		rdx(`DCP_ADDR_DST_POS, 32'h6);
		rdx(`DCP_ADDR_STATUS, 32'h2);
		`CHK("bytes", 6, n_acc)
		$display("test transfer done");
		go <= 1'b0;
		n_acc = 0;
		@(posedge ref_clk);
		base <= rs;
		go <= 1'b1;
		bus(1'b1, `DCP_ADDR_MATCH, {24'h0, rs + 8'h02});
		bus(1'b1, `DCP_ADDR_SRC_LEN, 32'h10);
		bus(1'b1, `DCP_ADDR_CELL_SZ, 32'h10);
		bus(1'b1, `DCP_ADDR_CTRL, 32'h3);
		pulse();
		settle(3);
		rdx(`DCP_ADDR_SRC_POS, 32'h0);
		rdx(`DCP_ADDR_CELL_POS, 32'h0);
		rdx(`DCP_ADDR_STATUS, 32'h4);
		`CHK("bytes", 3, n_acc)
		bus(1'b1, `DCP_ADDR_STATUS, 32'h4);
		rdx(`DCP_ADDR_STATUS, 32'h0);
		$display("test pattern done");
		print_verdict();
	end
endmodule
